// ===== core/pca_wave_pkg.sv
// Purpose: shared constants for the counter array waveform block
// Assumes: 32-bit Avalon-MM register bus, one word per register
// Notes: offsets are byte addresses
package pca_wave_pkg;

  // ************************************************
  // register map
  // ************************************************
  localparam logic [7:0] ADDR_COUNTER_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_COUNTER_MODE = 8'h04;
  localparam logic [7:0] ADDR_PWM_CONFIG = 8'h08;
  localparam logic [7:0] ADDR_COUNT = 8'h0c;
  // module n sits at (n + 1) * 16; word 0 mode, 1 low byte, 2 high byte
  localparam logic [1:0] SUB_MODULE_MODE = 2'h0;
  localparam logic [1:0] SUB_COMPARE_LOW = 2'h1;
  localparam logic [1:0] SUB_COMPARE_HIGH = 2'h2;

  // ************************************************
  // field positions
  // ************************************************
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_OVF_BIT = 1;
  localparam int CTRL_MATCH_LSB = 8;
  localparam int PWMCFG_CYCLE_LENGTH_SELECT_LSB = 0;
  localparam int PWMCFG_RELOAD_ACCESS_SELECT_BIT = 5;
  localparam int PWMCFG_CYCLE_OVERFLOW_FLAG_BIT = 6;
  localparam int MM_MATCH_IRQ_BIT = 0;
  localparam int MM_PWM_BIT = 1;
  localparam int MM_TOGGLE_BIT = 2;
  localparam int MM_MATCH_FLAG_BIT = 3;
  localparam int MM_COMPARATOR_BIT = 6;
  localparam int MM_WIDE_PWM_BIT = 7;

  // ************************************************
  // encodings and counts
  // ************************************************
  localparam logic [2:0] CPS_DIV12 = 3'h0;
  localparam logic [2:0] CPS_DIV4 = 3'h1;
  localparam logic [2:0] CPS_EXT_EDGE = 3'h2;
  localparam logic [3:0] PRESCALE_DIV12_LAST = 4'hb;
  localparam logic [3:0] PRESCALE_DIV4_LAST = 4'h3;
  localparam logic [1:0] CYCLE_LENGTH_SELECT_8BIT = 2'h0;
  localparam logic [1:0] CYCLE_LENGTH_SELECT_9BIT = 2'h1;
  localparam logic [1:0] CYCLE_LENGTH_SELECT_10BIT = 2'h2;
  localparam logic [15:0] MASK_8BIT = 16'h00ff;
  localparam logic [15:0] MASK_9BIT = 16'h01ff;
  localparam logic [15:0] MASK_10BIT = 16'h03ff;
  localparam logic [15:0] MASK_11BIT = 16'h07ff;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [15:0] RESET_WORD = 16'h0000;

  typedef enum logic [4:0] {
    WAVE_OTHER = 5'b00001,
    WAVE_FREQ = 5'b00010,
    WAVE_PWM8 = 5'b00100,
    WAVE_PWM_ENABLE = 5'b01000,
    WAVE_PWM16 = 5'b10000
  } wave_mode_t;

endpackage

// ===== core/pca_waveform.sv
// Purpose: shared 16-bit counter and waveform modes of the compare modules
// Assumes: i_mclk 40 MHz, synchronous active-high reset, Avalon-MM slave
// Notes: capture, software timer and watchdog modes are not in this block
//
// The register addresses and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none

// What this block and its software do
// (R1) high byte sets clocks between toggles
// (R2) low byte match toggles, adds high byte
// (R3) comparator, toggle, pwm bits select frequency mode
// (R4) frequency mode flags full 16-bit match
// (R5) 8-11 bit modules share one cycle length
// (R6) 8-bit: match sets, low overflow clears
// (R7) 8-bit: low byte reloads from high byte
// (R8) comparator, pwm, length 00 select 8-bit
// (R9) 8-bit match sets match flag
// (R10) 8-bit overflow sets cycle flag every 256
// (R11) low write clears, high write sets comparator
// (R12) software writes low byte before high
// (R13) comparator off gives zero duty in pwm
// (R14) reload select steers compare byte accesses
// (R15) software writes right-justified reload values
// (R16) n-bit: match sets, bit n overflow clears
// (R17) n-bit overflow sets flag, loads reload
// (R18) other lengths select 9, 10, 11 bit
// (R19) n-bit periods 512/1024/2048, match flags
// (R20) wide pwm bit selects 16-bit pwm
// (R21) 16-bit match flag, counter overflow flag
// (R22) software syncs 16-bit writes to matches
// (R23) shared counter increments per selected tick
module pca_waveform #(
  parameter int NUM_MODULES = 2
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_reset,
  // external counter clock pin
  input wire logic i_ext_count_clk,
  // avalon-mm slave
  input wire logic [7:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  input wire logic [3:0] i_byteenable,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  // module pins
  output logic [NUM_MODULES-1:0] o_module_output_pin
);

  typedef struct packed {
    logic [15:0] count;
    logic run;
    logic counter_overflow_flag;
    logic [2:0] clock_source_select;
    logic [3:0] prescale;
    logic [1:0] cycle_length_select;
    logic reload_access_select;
    logic cycle_overflow_flag;
    logic [NUM_MODULES-1:0][7:0] module_mode;
    logic [NUM_MODULES-1:0][15:0] compare_value;
    logic [NUM_MODULES-1:0][15:0] reload_value;
    logic [NUM_MODULES-1:0] match_flag;
    logic [NUM_MODULES-1:0] pin;
    logic ext_s1;
    logic ext_s2;
    logic ext_s3;
    logic waitreq;
    logic [31:0] rdata;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  // ************************************************
  // counter tick
  // ************************************************
  logic src_tick;
  logic tick;
  logic [15:0] cnt_inc;
  logic [15:0] len_mask;

  always_comb begin
    case (st_r.clock_source_select)
      pca_wave_pkg::CPS_DIV12: src_tick = (st_r.prescale == pca_wave_pkg::PRESCALE_DIV12_LAST);
      pca_wave_pkg::CPS_DIV4: src_tick = (st_r.prescale == pca_wave_pkg::PRESCALE_DIV4_LAST);
      pca_wave_pkg::CPS_EXT_EDGE: src_tick = st_r.ext_s2 & ~st_r.ext_s3;
      default: src_tick = 1'b1;
    endcase
  end

  assign tick = st_r.run & src_tick;
  // comparisons look at the value the counter is about to take, so the pin
  // changes in the same clock as the counter reaches it
  assign cnt_inc = st_r.count + 16'h0001; // [R23]

  // one length for every module in 8-11 bit mode
  always_comb begin
    case (st_r.cycle_length_select) // [R5]
      pca_wave_pkg::CYCLE_LENGTH_SELECT_8BIT: len_mask = pca_wave_pkg::MASK_8BIT;
      pca_wave_pkg::CYCLE_LENGTH_SELECT_9BIT: len_mask = pca_wave_pkg::MASK_9BIT;
      pca_wave_pkg::CYCLE_LENGTH_SELECT_10BIT: len_mask = pca_wave_pkg::MASK_10BIT;
      default: len_mask = pca_wave_pkg::MASK_11BIT;
    endcase
  end

  // ************************************************
  // per-module waveform events
  // ************************************************
  logic [NUM_MODULES-1:0] ev_high;
  logic [NUM_MODULES-1:0] ev_low;
  logic [NUM_MODULES-1:0] ev_toggle;
  logic [NUM_MODULES-1:0] ev_match;
  logic [NUM_MODULES-1:0] ev_cycle_overflow_flag;
  logic [NUM_MODULES-1:0] ev_load;
  logic [NUM_MODULES-1:0][15:0] load_val;

  genvar g;
  generate
    for (g = 0; g < NUM_MODULES; g++) begin : g_mod
      pca_wave_pkg::wave_mode_t mode;
      logic ecom;
      logic mat;
      logic [15:0] cp;
      logic [15:0] eff;
      logic wrap8;
      logic wrapn;

      assign ecom = st_r.module_mode[g][pca_wave_pkg::MM_COMPARATOR_BIT];
      assign mat = st_r.module_mode[g][pca_wave_pkg::MM_MATCH_FLAG_BIT];
      assign cp = st_r.compare_value[g];
      assign wrap8 = (cnt_inc[7:0] == pca_wave_pkg::RESET_BYTE);
      assign wrapn = ((cnt_inc & len_mask) == pca_wave_pkg::RESET_WORD);

      always_comb begin
        if (st_r.module_mode[g][pca_wave_pkg::MM_PWM_BIT]) begin
          if (st_r.module_mode[g][pca_wave_pkg::MM_WIDE_PWM_BIT]) begin
            mode = pca_wave_pkg::WAVE_PWM16; // [R20]
          end else if (st_r.module_mode[g][pca_wave_pkg::MM_TOGGLE_BIT]) begin
            mode = pca_wave_pkg::WAVE_FREQ; // [R3]
          end else if (st_r.cycle_length_select == pca_wave_pkg::CYCLE_LENGTH_SELECT_8BIT) begin
            mode = pca_wave_pkg::WAVE_PWM8; // [R8]
          end else begin
            mode = pca_wave_pkg::WAVE_PWM_ENABLE; // [R18]
          end
        end else begin
          mode = pca_wave_pkg::WAVE_OTHER;
        end
      end

      always_comb begin
        ev_high[g] = 1'b0;
        ev_low[g] = 1'b0;
        ev_toggle[g] = 1'b0;
        ev_match[g] = 1'b0;
        ev_cycle_overflow_flag[g] = 1'b0;
        ev_load[g] = 1'b0;
        load_val[g] = cp;
        eff = cp;
        case (mode)
          pca_wave_pkg::WAVE_FREQ: begin
            if (tick && ecom && cnt_inc[7:0] == cp[7:0]) begin
              ev_toggle[g] = 1'b1; // [R2]
              ev_load[g] = 1'b1;
              // a zero high byte adds 256, leaving the low byte as is
              load_val[g] = {cp[15:8], 8'(cp[7:0] + cp[15:8])}; // [R1] [R2]
            end
            ev_match[g] = tick && mat && cnt_inc == cp; // [R4]
          end
          pca_wave_pkg::WAVE_PWM8: begin
            if (tick && wrap8) begin
              ev_low[g] = 1'b1; // [R6]
              ev_cycle_overflow_flag[g] = 1'b1; // [R10]
              ev_load[g] = 1'b1;
              load_val[g] = {cp[15:8], cp[15:8]}; // [R7]
              eff = load_val[g];
            end
            if (tick && ecom && cnt_inc[7:0] == eff[7:0]) begin
              ev_high[g] = 1'b1; // [R6]
              ev_match[g] = mat; // [R9]
            end
          end
          pca_wave_pkg::WAVE_PWM_ENABLE: begin
            if (tick && wrapn) begin
              ev_low[g] = 1'b1; // [R16]
              ev_cycle_overflow_flag[g] = 1'b1; // [R17] [R19]
              ev_load[g] = 1'b1;
              load_val[g] = st_r.reload_value[g]; // [R17]
              eff = load_val[g];
            end
            if (tick && ecom && (cnt_inc & len_mask) == (eff & len_mask)) begin
              ev_high[g] = 1'b1; // [R16]
              ev_match[g] = mat; // [R19]
            end
          end
          pca_wave_pkg::WAVE_PWM16: begin
            if (tick && cnt_inc == pca_wave_pkg::RESET_WORD) begin
              ev_low[g] = 1'b1; // [R20]
            end
            if (tick && ecom && cnt_inc == cp) begin
              ev_high[g] = 1'b1; // [R20]
              ev_match[g] = mat; // [R21]
            end
          end
          default: begin
          end
        endcase
        // comparator off in any pwm mode pins the output low
        if (!ecom && mode != pca_wave_pkg::WAVE_FREQ && mode != pca_wave_pkg::WAVE_OTHER) begin
          ev_low[g] = 1'b1; // [R13]
          ev_high[g] = 1'b0; // [R13]
        end
      end
    end
  endgenerate

  // ************************************************
  // register decode
  // ************************************************
  logic [3:0] slot;
  logic mod_hit;
  logic [3:0] mod_idx;
  logic [1:0] sub;
  logic [31:0] rmux;

  assign slot = i_address[7:4];
  assign sub = i_address[3:2];
  assign mod_idx = slot - 4'h1;
  assign mod_hit = (slot != 4'h0) && (32'(mod_idx) < NUM_MODULES) && (i_address[1:0] == 2'h0);

  always_comb begin
    rmux = '0;
    if (mod_hit) begin
      case (sub)
        pca_wave_pkg::SUB_MODULE_MODE: rmux[7:0] = st_r.module_mode[mod_idx];
        pca_wave_pkg::SUB_COMPARE_LOW: rmux[7:0] = st_r.reload_access_select ?
          st_r.reload_value[mod_idx][7:0] : st_r.compare_value[mod_idx][7:0]; // [R14]
        pca_wave_pkg::SUB_COMPARE_HIGH: rmux[7:0] = st_r.reload_access_select ?
          st_r.reload_value[mod_idx][15:8] : st_r.compare_value[mod_idx][15:8]; // [R14]
        default: rmux = '0;
      endcase
    end else begin
      case (i_address)
        pca_wave_pkg::ADDR_COUNTER_CONTROL: begin
          rmux[pca_wave_pkg::CTRL_RUN_BIT] = st_r.run;
          rmux[pca_wave_pkg::CTRL_OVF_BIT] = st_r.counter_overflow_flag;
          rmux[pca_wave_pkg::CTRL_MATCH_LSB +: NUM_MODULES] = st_r.match_flag;
        end
        pca_wave_pkg::ADDR_COUNTER_MODE: rmux[2:0] = st_r.clock_source_select;
        pca_wave_pkg::ADDR_PWM_CONFIG: begin
          rmux[pca_wave_pkg::PWMCFG_CYCLE_LENGTH_SELECT_LSB +: 2] = st_r.cycle_length_select;
          rmux[pca_wave_pkg::PWMCFG_RELOAD_ACCESS_SELECT_BIT] = st_r.reload_access_select;
          rmux[pca_wave_pkg::PWMCFG_CYCLE_OVERFLOW_FLAG_BIT] = st_r.cycle_overflow_flag;
        end
        pca_wave_pkg::ADDR_COUNT: rmux[15:0] = st_r.count;
        default: rmux = '0;
      endcase
    end
  end

  // ************************************************
  // next state
  // ************************************************
  logic do_write;
  assign do_write = i_write && !st_r.waitreq;

  always_comb begin
    st_nxt = st_r;
    st_nxt.ext_s1 = i_ext_count_clk;
    st_nxt.ext_s2 = st_r.ext_s1;
    st_nxt.ext_s3 = st_r.ext_s2;
    if (src_tick || st_r.clock_source_select > pca_wave_pkg::CPS_DIV4) begin
      st_nxt.prescale = 4'h0;
    end else begin
      st_nxt.prescale = st_r.prescale + 4'h1;
    end
    if (tick) begin
      st_nxt.count = cnt_inc; // [R23]
    end

    // one wait cycle, then the answer; data is latched while waitrequest is high
    if (st_r.waitreq) begin
      if (i_read || i_write) begin
        st_nxt.waitreq = 1'b0;
        st_nxt.rdata = rmux;
      end
    end else begin
      st_nxt.waitreq = 1'b1;
    end

    // software writes first; hardware events after, so a set beats a clear
    if (do_write && i_byteenable[0]) begin
      if (mod_hit) begin
        case (sub)
          pca_wave_pkg::SUB_MODULE_MODE: st_nxt.module_mode[mod_idx] = i_writedata[7:0];
          pca_wave_pkg::SUB_COMPARE_LOW: begin
            if (st_r.reload_access_select) begin
              st_nxt.reload_value[mod_idx][7:0] = i_writedata[7:0]; // [R14] [R15]
            end else begin
              st_nxt.compare_value[mod_idx][7:0] = i_writedata[7:0]; // [R14]
            end
            st_nxt.module_mode[mod_idx][pca_wave_pkg::MM_COMPARATOR_BIT] = 1'b0; // [R11] [R12]
          end
          pca_wave_pkg::SUB_COMPARE_HIGH: begin
            if (st_r.reload_access_select) begin
              st_nxt.reload_value[mod_idx][15:8] = i_writedata[7:0]; // [R14]
            end else begin
              st_nxt.compare_value[mod_idx][15:8] = i_writedata[7:0]; // [R14]
            end
            st_nxt.module_mode[mod_idx][pca_wave_pkg::MM_COMPARATOR_BIT] = 1'b1; // [R11] [R12]
          end
          default: begin
          end
        endcase
      end else begin
        case (i_address)
          pca_wave_pkg::ADDR_COUNTER_CONTROL: begin
            st_nxt.run = i_writedata[pca_wave_pkg::CTRL_RUN_BIT];
            if (i_writedata[pca_wave_pkg::CTRL_OVF_BIT]) begin
              st_nxt.counter_overflow_flag = 1'b0;
            end
          end
          pca_wave_pkg::ADDR_COUNTER_MODE: st_nxt.clock_source_select = i_writedata[2:0];
          pca_wave_pkg::ADDR_PWM_CONFIG: begin
            st_nxt.cycle_length_select = i_writedata[pca_wave_pkg::PWMCFG_CYCLE_LENGTH_SELECT_LSB +: 2];
            st_nxt.reload_access_select = i_writedata[pca_wave_pkg::PWMCFG_RELOAD_ACCESS_SELECT_BIT];
            if (i_writedata[pca_wave_pkg::PWMCFG_CYCLE_OVERFLOW_FLAG_BIT]) begin
              st_nxt.cycle_overflow_flag = 1'b0;
            end
          end
          pca_wave_pkg::ADDR_COUNT: st_nxt.count[7:0] = i_writedata[7:0];
          default: begin
          end
        endcase
      end
    end
    if (do_write && i_byteenable[1]) begin
      if (!mod_hit && i_address == pca_wave_pkg::ADDR_COUNT) begin
        st_nxt.count[15:8] = i_writedata[15:8];
      end
      if (!mod_hit && i_address == pca_wave_pkg::ADDR_COUNTER_CONTROL) begin
        st_nxt.match_flag = st_r.match_flag & ~i_writedata[pca_wave_pkg::CTRL_MATCH_LSB +: NUM_MODULES];
      end
    end

    if (tick && cnt_inc == pca_wave_pkg::RESET_WORD) begin
      st_nxt.counter_overflow_flag = 1'b1; // [R21]
    end
    if (|ev_cycle_overflow_flag) begin
      st_nxt.cycle_overflow_flag = 1'b1; // [R10] [R17]
    end
    for (int m = 0; m < NUM_MODULES; m++) begin
      if (ev_match[m]) begin
        st_nxt.match_flag[m] = 1'b1; // [R4] [R9] [R21]
      end
      // a hardware reload yields to a compare write in the same clock
      if (ev_load[m] && !(do_write && mod_hit && 32'(mod_idx) == m &&
          sub != pca_wave_pkg::SUB_MODULE_MODE && !st_r.reload_access_select)) begin
        st_nxt.compare_value[m] = load_val[m]; // [R2] [R7] [R17]
      end
      // when match and wrap coincide the pin goes high: full duty
      if (ev_high[m]) begin
        st_nxt.pin[m] = 1'b1;
      end else if (ev_low[m]) begin
        st_nxt.pin[m] = 1'b0;
      end else if (ev_toggle[m]) begin
        st_nxt.pin[m] = ~st_r.pin[m]; // [R2]
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      st_r <= '0;
      st_r.waitreq <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_readdata = st_r.rdata;
  assign o_waitrequest = st_r.waitreq;
  assign o_module_output_pin = st_r.pin;

endmodule // pca_waveform

`default_nettype wire

// ===== tb/pca_waveform_chk.sv
// Purpose: port checks for the waveform block
// Assumes: timing checks only while the counter ticks every mclk
// Notes: config is shadowed from bus writes; pin 0 only
`timescale 1ns/10ps
`default_nettype none
module pca_waveform_chk #(
  parameter int NUM_MODULES = 2
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_reset,
  // watched bus and pins
  input wire logic i_ext_count_clk,
  input wire logic [7:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  input wire logic [3:0] i_byteenable,
  input wire logic [31:0] o_readdata,
  input wire logic o_waitrequest,
  input wire logic [NUM_MODULES-1:0] o_module_output_pin
);
  // ****************
  // config shadow
  // ****************
  logic [7:0] mode_r, high_r;
  logic [1:0] len_r;
  logic fast_r, sel_r, pin_r, seen_r, fseen_r;
  logic [15:0] gap_r, fgap_r;
  wire wr_now = i_write && !o_waitrequest;
  wire pin_now = o_module_output_pin[0];
  wire fell_now = pin_r && !pin_now;
  wire freq_on = fast_r && mode_r[1] && mode_r[2] && !mode_r[7];
  wire pwm_on = fast_r && mode_r[1] && !mode_r[2] && !mode_r[7];
  wire [15:0] half = (high_r == 8'h00) ? 16'h0100 : {8'h00, high_r};
  wire [15:0] span = (16'h0100 << len_r) - 16'h0001;
  always_ff @(posedge i_mclk) begin
    pin_r <= pin_now;
    gap_r <= (pin_r != pin_now) ? 16'h0001 : gap_r + 16'h0001;
    fgap_r <= fell_now ? 16'h0001 : fgap_r + 16'h0001;
    // any write may move the waveform, so the next edge only re-arms
    seen_r <= (i_reset || wr_now) ? 1'b0 : (seen_r || pin_r != pin_now);
    fseen_r <= (i_reset || wr_now) ? 1'b0 : (fseen_r || fell_now);
    if (i_reset) begin
      mode_r <= 8'h00;
      high_r <= 8'h00;
      len_r <= 2'h0;
      fast_r <= 1'b0;
      sel_r <= 1'b0;
    end else if (wr_now) begin
      case (i_address)
        8'h04: fast_r <= i_writedata[2:0] >= 3'h3;
        8'h08: {sel_r, len_r} <= {i_writedata[5], i_writedata[1:0]};
        8'h10: mode_r <= i_writedata[7:0];
        8'h18: high_r <= sel_r ? high_r : i_writedata[7:0];
        default: ;
      endcase
    end
  end
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset);
  a_req_answered: assert property ((i_read || i_write) && o_waitrequest |=> !o_waitrequest)
    else $error("request not answered");
  a_wait_single: assert property (!o_waitrequest |=> o_waitrequest)
    else $error("long answer");
  a_idle_wait: assert property (!i_read && !i_write |=> o_waitrequest)
    else $error("answer without request");
  a_reset_quiet: assert property (disable iff (1'b0) i_reset |=> o_waitrequest && o_module_output_pin == '0)
    else $error("reset not quiet");
  a_unmapped_zero: assert property (i_read && o_waitrequest && i_address == 8'hf0 |=> o_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_low_write_off: assert property (wr_now && i_address == 8'h14 && mode_r[1] && !mode_r[2] |-> ##[1:3] !pin_now)
    else $error("pin not low after low byte write");
  a_freq_toggle: assert property (pin_r != pin_now && seen_r && freq_on |-> gap_r == half)
    else $error("toggle spacing wrong");
  a_pwm_period: assert property (fell_now && fseen_r && pwm_on |-> (fgap_r & span) == 16'h0000)
    else $error("pwm period wrong");
  c_freq: cover property (pin_r != pin_now && seen_r && freq_on);
  c_pwm: cover property (fell_now && fseen_r && pwm_on);
  c_unmapped: cover property (i_read && i_address == 8'hf0 && !o_waitrequest);
endmodule // pca_waveform_chk
`default_nettype wire

// ===== tb/pin_load.sv
// Purpose: load on a module pin that times its pulses
// Assumes: pin sampled on the block clock
// Notes: period is rise to rise, high length rise to fall
`timescale 1ns/10ps
`default_nettype none
module pin_load (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_reset,
  // pin from the block
  input wire logic i_pin,
  // measured timing
  output logic [16:0] o_high_len,
  output logic [16:0] o_period,
  output logic [31:0] o_rises
);
  logic last_r;
  logic [16:0] hi_r, per_r;
  always_ff @(posedge i_mclk) begin
    last_r <= i_pin;
    per_r <= per_r + 17'h00001;
    hi_r <= hi_r + 17'h00001;
    if (i_reset) begin
      o_rises <= 32'h0;
      o_high_len <= 17'h00000;
      o_period <= 17'h00000;
    end else if (i_pin && !last_r) begin
      o_period <= per_r;
      per_r <= 17'h00001;
      hi_r <= 17'h00001;
      o_rises <= o_rises + 32'h1;
    end else if (!i_pin && last_r) begin
      o_high_len <= hi_r;
    end
  end
endmodule // pin_load
`default_nettype wire

// ===== tb/counter_array_waveform_modes_bench.sv
// Purpose: self-checking bench for the waveform block
// Assumes: counter ticks on every mclk (source 3) after the first external pin count check (source 2)
// Notes: a load model per pin times the pulses
`timescale 1ns/10ps
`default_nettype none
module counter_array_waveform_modes_bench;
  logic i_mclk = 1'b0, i_reset = 1'b1, i_read = 1'b0, i_write = 1'b0, ext_clk = 1'b0;
  logic [7:0] i_address = 8'h00;
  logic [31:0] i_writedata = 32'h0, o_readdata, rd;
  logic o_waitrequest;
  logic [1:0] o_module_output_pin;
  wire logic [16:0] hl [2];
  wire logic [16:0] per [2];
  wire logic [31:0] rises [2];
  int bad_count = 0, total_checks = 0, seed = 31211, n, r;
  logic [15:0] v;
  pca_waveform #(.NUM_MODULES(2)) pca_waveform_inst (.i_mclk(i_mclk), .i_reset(i_reset),
    .i_ext_count_clk(ext_clk), .i_address(i_address), .i_read(i_read), .i_write(i_write),
    .i_writedata(i_writedata), .i_byteenable(4'hf), .o_readdata(o_readdata),
    .o_waitrequest(o_waitrequest), .o_module_output_pin(o_module_output_pin));
  for (genvar g = 0; g < 2; g++) begin : g_load
    pin_load pin_load_inst (.i_mclk(i_mclk), .i_reset(i_reset), .i_pin(o_module_output_pin[g]),
      .o_high_len(hl[g]), .o_period(per[g]), .o_rises(rises[g]));
  end
  initial begin
    forever #12.5 i_mclk = ~i_mclk;
  end
  // waits as long as the slave asks; only the watchdog ends a hung access
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    i_read <= !wr;
    i_write <= wr;
    i_address <= a;
    i_writedata <= d;
    do begin
      @(posedge i_mclk);
    end while (o_waitrequest !== 1'b0);
    rd = o_readdata;
    i_read <= 1'b0;
    i_write <= 1'b0;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // bounded wait for a number of rising pin edges
  task automatic settle(input int k, input int cnt);
    int r0, t;
    r0 = rises[k];
    t = 0;
    while (rises[k] < r0 + cnt && t < 9000) begin
      @(posedge i_mclk);
      t++;
    end
    bad_count += (t >= 9000);
  endtask
  function automatic logic [31:0] freq_half(input logic [7:0] h);
    return (h == 8'h00) ? 32'h100 : {24'h0, h};
  endfunction
  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge i_mclk);
    bad_count++;
    print_verdict();
  end
  initial begin
    repeat (6) @(posedge i_mclk);
    i_reset <= 1'b0;
    // external pin source: each rising pin edge is one count
    bus(1'b1, 8'h04, 32'h2);
    bus(1'b1, 8'h00, 32'h1);
    bus(1'b1, 8'h0c, 32'h0);
    repeat (5) begin
      ext_clk <= 1'b1;
      repeat (3) @(posedge i_mclk);
      ext_clk <= 1'b0;
      repeat (3) @(posedge i_mclk);
    end
    bus(1'b0, 8'h0c, 32'h0);
    check(rd, 32'h5);
    bus(1'b1, 8'h04, 32'h3);
    bus(1'b0, 8'hf0, 32'h0);
    check(rd, 32'h0);
    // ****************
    // frequency output
    // ****************
    for (n = 0; n < 3; n++) begin
      v = (n == 0) ? 16'h0000 : 16'h0001 + 16'($random(seed) & 32'h3f);
      bus(1'b1, 8'h10, 32'h46);
      bus(1'b1, 8'h14, 32'h0);
      bus(1'b0, 8'h10, 32'h0);
      check(rd, 32'h06);
      bus(1'b1, 8'h18, {24'h0, v[7:0]});
      bus(1'b0, 8'h10, 32'h0);
      check(rd, 32'h46);
      settle(0, 3);
      check(32'(hl[0]), freq_half(v[7:0]));
      check(32'(per[0]), freq_half(v[7:0]) << 1);
    end
    // ****************
    // 8-bit pwm; low byte differs so only the reload gives the duty
    // ****************
    for (n = 0; n < 3; n++) begin
      v = (n == 0) ? 16'h00ff : 16'h0001 | 16'($random(seed) & 32'hff);
      bus(1'b1, 8'h10, 32'h4a);
      bus(1'b1, 8'h14, {24'h0, ~v[7:0]});
      bus(1'b1, 8'h18, {24'h0, v[7:0]});
      bus(1'b1, 8'h00, 32'h0103);
      bus(1'b1, 8'h08, 32'h40);
      settle(0, 3);
      check(32'(per[0]), 32'h100);
      check(32'(hl[0]), 32'h100 - v);
      bus(1'b0, 8'h00, 32'h0);
      check({31'h0, rd[8]}, 32'h1);
      bus(1'b0, 8'h08, 32'h0);
      check({31'h0, rd[6]}, 32'h1);
    end
    bus(1'b1, 8'h14, 32'h10);
    r = rises[0];
    repeat (600) @(posedge i_mclk);
    check(rises[0] - r, 32'h0);
    // ****************
    // 9, 10, 11-bit pwm on both modules through the reload bytes
    // ****************
    for (n = 1; n < 4; n++) begin
      v = 16'h0001 + 16'($random(seed) & ((32'h100 << n) - 32'h2));
      bus(1'b1, 8'h08, 32'h20 | n);
      for (r = 1; r < 3; r++) begin
        bus(1'b1, 8'(r << 4), 32'h42);
        bus(1'b1, 8'(r << 4) + 8'h4, {24'h0, v[7:0]});
        bus(1'b1, 8'(r << 4) + 8'h8, {24'h0, v[15:8]});
      end
      bus(1'b0, 8'h14, 32'h0);
      check(rd, {24'h0, v[7:0]});
      bus(1'b1, 8'h08, 32'h40 | n);
      settle(0, 3);
      check(32'(per[0]), 32'h100 << n);
      check(32'(per[1]), 32'h100 << n);
      check(32'(hl[0]), (32'h100 << n) - v);
      bus(1'b0, 8'h14, 32'h0);
      check(rd, {24'h0, v[7:0]});
      bus(1'b0, 8'h08, 32'h0);
      check({31'h0, rd[6]}, 32'h1);
    end
    // ****************
    // 16-bit pwm, counter moved close to the match
    // ****************
    bus(1'b1, 8'h08, 32'h0);
    bus(1'b1, 8'h10, 32'hcb);
    bus(1'b1, 8'h14, 32'h0);
    bus(1'b1, 8'h18, 32'hff);
    bus(1'b1, 8'h00, 32'h0103);
    bus(1'b1, 8'h0c, 32'hfe00);
    settle(0, 1);
    repeat (300) @(posedge i_mclk);
    check(32'(hl[0]), 32'h100);
    bus(1'b0, 8'h00, 32'h0);
    check(rd & 32'h103, 32'h103);
    print_verdict();
  end
endmodule // counter_array_waveform_modes_bench
bind pca_waveform pca_waveform_chk #(.NUM_MODULES(NUM_MODULES)) pca_waveform_chk_inst (.i_mclk(i_mclk),
  .i_reset(i_reset), .i_ext_count_clk(i_ext_count_clk), .i_address(i_address), .i_read(i_read),
  .i_write(i_write), .i_writedata(i_writedata), .i_byteenable(i_byteenable), .o_readdata(o_readdata),
  .o_waitrequest(o_waitrequest), .o_module_output_pin(o_module_output_pin));
`default_nettype wire
